// ==== stc_selftest_ctrl.sv ====
/*
  Self-test control register of the primary side. Holds the 16-bit control
  word, turns each accepted one written to a check bit into a start pulse for the check logic (bit 7 only in configuration 2), and
  keeps sticky fault flags fed by the check logic.
  Assumes the serial link delivers a decoded register strobe synchronous to
  clk, and that the state machine of the device supplies its operating state
  and the configuration crc disable bit.
*/
`timescale 1ns/1ns
module stc_selftest_ctrl
  import stc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register strobe from the serial link
  input wire logic wr_en,
  input wire logic [STC_REG_W-1:0] wr_data,
  output logic [STC_REG_W-1:0] rd_data,
  output logic wr_locked,
  // device context
  input wire stc_dev_state_t dev_state,
  input wire logic config_crc_disable,
  // to the check logic
  output stc_chk_t chk_start,
  output logic link_crc_clear,
  output stc_chk_t chk_busy,
  // from the check logic and status clear
  input wire stc_chk_t chk_fault_in,
  input wire stc_chk_t fault_clr,
  output stc_chk_t fault_flags
);

  // ------------------------------------------------------------
  // write qualification
  // ------------------------------------------------------------
  logic [STC_REG_W-1:0] ctrl_r;
  logic [STC_REG_W-1:0] wmask;
  logic [STC_REG_W-1:0] ones_wr;
  logic locked;
  stc_chk_t req;
  stc_chk_t busy_r;
  stc_chk_t flags_r;

  // host is expected to drop the crc guard first in active [R1]
  assign locked = (dev_state == STC_ST_ACTIVE) && !config_crc_disable;
  // the link crc clear bit stays open while locked [R2]
  assign wmask = locked ? STC_CTRL_OPEN_MASK : STC_CTRL_RW_MASK;
  assign ones_wr = (wr_en ? wr_data : '0) & wmask;
  assign wr_locked = locked;

  assign req.cfg_crc = ones_wr[STC_BIT_CFG_CRC_CHK]; // [R4]
  // pwm check refused outside configuration 2 [R6]
  assign req.pwm_cmp = ones_wr[STC_BIT_PWM_CMP_CHK] && (dev_state == STC_ST_CONFIG2); // [R5]
  assign req.shoot_through_protection = ones_wr[STC_BIT_SHOOT_THROUGH_CHECK]; // [R7]
  assign req.clk_mon = ones_wr[STC_BIT_CLK_MON_CHK]; // [R9]

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= STC_CTRL_RST;
    end else if (wr_en) begin
      // reserved read-only bits never store [R3] [R8]
      ctrl_r <= ((ctrl_r & ~wmask) | (wr_data & wmask)) & STC_CTRL_RW_MASK;
    end
  end

  // reads never wait on a running check [R10]
  assign rd_data = ctrl_r; // [R3] [R8]

  // ------------------------------------------------------------
  // start pulses, one per accepted one written to a check bit, bit 7 only in configuration 2
  // ------------------------------------------------------------
  // pulse, not level: a stored one must not retrigger the check [R11]
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chk_start <= STC_CHK_NONE;
      link_crc_clear <= 1'b0;
    end else begin
      chk_start <= req;
      link_crc_clear <= ones_wr[STC_BIT_LINK_CRC_CLR]; // [R2]
    end
  end

  // ------------------------------------------------------------
  // busy tracking, ended by the check's own fault answer
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_r <= STC_CHK_NONE;
    end else begin
      busy_r <= (busy_r | chk_start) & ~chk_fault_in;
    end
  end
  assign chk_busy = busy_r;

  // ------------------------------------------------------------
  // sticky fault flags
  // ------------------------------------------------------------
  // set beats clear in the same cycle so no fault is lost
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags_r <= STC_CHK_NONE;
    end else begin
      flags_r <= (flags_r & ~fault_clr) | chk_fault_in; // [R5] [R7] [R9] [R11]
    end
  end
  assign fault_flags = flags_r;

  // ------------------------------------------------------------
  // checks on the register path
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // rd_data is the flop itself, so this watches the write mask
  a_rsvd_read_zero: assert property ((rd_data & ~STC_CTRL_RW_MASK) == '0) // [R3] [R8]
    else $error("reserved control bits read nonzero");

  a_spare_bit_rw: assert property (wr_en && !locked // [R8]
      |=> rd_data[STC_BIT_SPARE] == $past(wr_data[STC_BIT_SPARE]))
    else $error("spare bit did not store write");

  a_idle_hold: assert property (!wr_en |=> $stable(rd_data)) // [R8]
    else $error("control word changed without a write");

  // only the link crc clear bit may move under the crc guard
  a_locked_write_hold: assert property (wr_en && locked // [R1]
      |=> (rd_data & ~STC_CTRL_OPEN_MASK) == ($past(rd_data) & ~STC_CTRL_OPEN_MASK))
    else $error("locked write changed guarded bits");

  a_link_clr_open: assert property (wr_en && wr_data[STC_BIT_LINK_CRC_CLR] // [R2]
      |=> link_crc_clear && rd_data[STC_BIT_LINK_CRC_CLR])
    else $error("link crc clear write not taken");

  a_link_clr_pulse: assert property (link_crc_clear // [R2]
      |-> $past(wr_en && wr_data[STC_BIT_LINK_CRC_CLR]))
    else $error("link crc clear pulse without a write");

  // a running clock check must not stall the register path
  a_clk_mon_live: assert property (busy_r.clk_mon && wr_en && !locked // [R10] [R9]
      |=> rd_data == ($past(wr_data) & STC_CTRL_RW_MASK))
    else $error("write lost during clock monitor check");

  // ------------------------------------------------------------
  // checks on the start pulses
  // ------------------------------------------------------------
  a_crc_chk_start: assert property (wr_en && !locked && wr_data[STC_BIT_CFG_CRC_CHK] // [R4]
      |=> chk_start.cfg_crc)
    else $error("config crc check not started");

  a_crc_chk_once: assert property (chk_start.cfg_crc // [R4] [R11]
      |=> !chk_start.cfg_crc || $past(wr_en && !locked && wr_data[STC_BIT_CFG_CRC_CHK]))
    else $error("config crc start held past one cycle");

  a_pwm_chk_start: assert property (wr_en && wr_data[STC_BIT_PWM_CMP_CHK] && dev_state == STC_ST_CONFIG2 // [R5]
      |=> chk_start.pwm_cmp)
    else $error("pwm check not started");

  // refused outside configuration 2, though the bit still stores when not locked
  a_pwm_state_gate: assert property (chk_start.pwm_cmp |-> $past(dev_state) == STC_ST_CONFIG2) // [R6]
    else $error("pwm check started outside configuration 2");

  a_pwm_refused: assert property (wr_en && dev_state != STC_ST_CONFIG2 // [R6]
      |=> !chk_start.pwm_cmp)
    else $error("pwm check not refused");

  a_shoot_through_check_start: assert property (wr_en && !locked && wr_data[STC_BIT_SHOOT_THROUGH_CHECK] // [R7] [R11]
      |=> chk_start.shoot_through_protection ##1 (!chk_start.shoot_through_protection || $past(wr_en && !locked && wr_data[STC_BIT_SHOOT_THROUGH_CHECK])))
    else $error("shoot-through start not a single pulse");

  a_clk_mon_start: assert property (wr_en && !locked && wr_data[STC_BIT_CLK_MON_CHK] // [R9]
      |=> chk_start.clk_mon)
    else $error("clock monitor check not started");

  a_locked_no_start: assert property (wr_en && locked |=> chk_start == STC_CHK_NONE) // [R1]
    else $error("check started by a locked write");

  // a stored one must never fire again on its own
  a_no_write_no_start: assert property (!wr_en |=> chk_start == STC_CHK_NONE && !link_crc_clear) // [R11]
    else $error("start pulse without a write");

  // ------------------------------------------------------------
  // checks on busy and the fault flags
  // ------------------------------------------------------------
  a_crc_busy_set: assert property (chk_start.cfg_crc && !chk_fault_in.cfg_crc |=> chk_busy.cfg_crc) // [R4]
    else $error("config crc check not marked busy");

  a_pwm_busy_set: assert property (chk_start.pwm_cmp && !chk_fault_in.pwm_cmp |=> chk_busy.pwm_cmp) // [R5]
    else $error("pwm check not marked busy");

  a_busy_set: assert property (chk_start.shoot_through_protection && !chk_fault_in.shoot_through_protection |=> chk_busy.shoot_through_protection) // [R7]
    else $error("shoot-through check not marked busy");

  a_busy_ends: assert property (chk_fault_in.clk_mon |=> !chk_busy.clk_mon) // [R9]
    else $error("clock monitor busy outlived its fault");

  a_pwm_fault_set: assert property (chk_fault_in.pwm_cmp |=> fault_flags.pwm_cmp) // [R5]
    else $error("pwm compare fault not flagged");

  a_clk_fault_set: assert property (chk_fault_in.clk_mon |=> fault_flags.clk_mon) // [R9]
    else $error("clock monitor fault not flagged");

  // set beats clear, so a fault landing on a clear still shows
  a_fault_set_wins: assert property (chk_fault_in.shoot_through_protection |=> flags_r.shoot_through_protection) // [R7] [R11]
    else $error("fault lost against clear");

  a_fault_sticky: assert property (flags_r.clk_mon && !fault_clr.clk_mon |=> flags_r.clk_mon [*1]) // [R11]
    else $error("fault flag dropped without clear");

  a_fault_clear: assert property (fault_clr.shoot_through_protection && !chk_fault_in.shoot_through_protection |=> !flags_r.shoot_through_protection) // [R11]
    else $error("fault flag survived its clear");

  // ------------------------------------------------------------
  // main scenarios
  // ------------------------------------------------------------
  c_locked_link_clr: cover property (locked && wr_en && wr_data[STC_BIT_LINK_CRC_CLR]);
  c_pwm_refused: cover property (wr_en && wr_data[STC_BIT_PWM_CMP_CHK] && dev_state != STC_ST_CONFIG2);
  c_clk_mon_fault: cover property (chk_start.clk_mon ##[1:20] chk_fault_in.clk_mon);
  c_set_and_clear: cover property (chk_fault_in.pwm_cmp && fault_clr.pwm_cmp);
  c_locked_refused: cover property (locked && wr_en && wr_data[STC_BIT_SPARE]);

endmodule

// ==== stc_pkg.sv ====
/*
  Package for the gate driver self-test control block: register layout, reset
  values, device operating states and the packed carriers shared by ports.
  Assumes the serial management link decodes the register address and hands
  over one 16-bit write or read strobe per transaction.
*/
//
// Contract
// [R1] In the active state the host sets the configuration crc disable bit before writing new control data.
// [R2] A write to the link crc clear bit is taken in the active state even with the configuration crc check on.
// [R3] Bits 14 to 9 are read-only and always read as zero.
// [R4] Writing one to bit 8 starts a crc check of the primary supply side configuration bits; reset value zero.
// [R5] Writing one to bit 7 starts the pwm compare check, whose forced fault sets the pwm compare check fault.
// [R6] The pwm compare check runs only in the configuration 2 state and never in another state.
// [R7] Writing one to bit 5 starts the shoot-through check, whose fault sets the shoot-through fault.
// [R8] Bit 6 is a plain read/write bit resetting to zero, and bits 4 to 1 are read-only zero.
// [R9] Writing one to bit 0 starts the primary clock monitor check, whose fault sets the clock monitor fault.
// [R10] Register reads and writes keep working while the primary clock monitor check runs.
// [R11] Each write of one starts its check once, and each fault flag holds until the host clears it.
package stc_pkg;

  // ------------------------------------------------------------
  // register layout
  // ------------------------------------------------------------
  localparam int unsigned STC_REG_W = 16;
  localparam int unsigned STC_BIT_LINK_CRC_CLR = 15;
  localparam int unsigned STC_BIT_CFG_CRC_CHK = 8;
  localparam int unsigned STC_BIT_PWM_CMP_CHK = 7;
  localparam int unsigned STC_BIT_SPARE = 6;
  localparam int unsigned STC_BIT_SHOOT_THROUGH_CHECK = 5;
  localparam int unsigned STC_BIT_CLK_MON_CHK = 0;
  localparam logic [15:0] STC_CTRL_RST = 16'h0000;
  // bits that store a value; all others read zero
  localparam logic [15:0] STC_CTRL_RW_MASK = 16'h81E1;
  // only bit a crc-locked write may still change
  localparam logic [15:0] STC_CTRL_OPEN_MASK = 16'h8000;

  // ------------------------------------------------------------
  // device operating states, gray coded along the power-up path
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    STC_ST_CONFIG1 = 2'h0,
    STC_ST_CONFIG2 = 2'h1,
    STC_ST_ACTIVE  = 2'h3,
    STC_ST_FAULT   = 2'h2
  } stc_dev_state_t;

  // one bit per diagnostic check
  typedef struct packed {
    logic cfg_crc;
    logic pwm_cmp;
    logic shoot_through_protection;
    logic clk_mon;
  } stc_chk_t;

  localparam stc_chk_t STC_CHK_NONE = '0;

endpackage

// ==== stc_chk_model.sv ====
/*
  model of the check logic beside the self-test block: answers the newest start
  pulse of each check with a one-cycle fault pulse after a short delay.
  assumes start pulses on the same clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module stc_chk_model
  import stc_pkg::*;
#(parameter int LAT = 2)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // check handshake
  input wire stc_chk_t start,
  output stc_chk_t fault
);
  // ------------------------------------------------------------
  // per-check countdown; higher bits answer later, so busy overlaps
  // ------------------------------------------------------------
  logic [3:0][3:0] cnt_r;
  logic [3:0] st;
  logic [3:0] f;
  assign st = start;
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_b) cnt_r[i] <= 4'h0;
      else if (st[i]) cnt_r[i] <= 4'(LAT + i);
      else if (cnt_r[i] != 4'h0) cnt_r[i] <= cnt_r[i] - 4'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) f[i] = (cnt_r[i] == 4'h1);
  end
  assign fault = stc_chk_t'(f);
endmodule

// ==== testbench.sv ====
/*
  self-checking bench for the self-test control register.
  assumes the decoded write strobe interface and the check logic model.
*/
`timescale 1ns/1ns
module testbench
  import stc_pkg::*;
;
  // ------------------------------------------------------------
  // signals, scoreboard and helpers
  // ------------------------------------------------------------
  typedef struct packed {logic [15:0] rd; logic [3:0] st; logic lc;} stc_note_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_en = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] rd_data;
  logic [15:0] shadow = 16'h0000;
  logic wr_locked;
  logic link_crc_clear;
  logic config_crc_disable = 1'b0;
  stc_dev_state_t dev_state = STC_ST_CONFIG1;
  stc_chk_t chk_start, chk_busy, chk_fault_in, fault_flags;
  stc_chk_t fault_clr = STC_CHK_NONE;
  int n_fail = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h00000043;
  stc_note_t notes[$];
  stc_note_t mon;
  always #5 clk = ~clk;
  stc_selftest_ctrl dut (.clk(clk), .rst_b(rst_b), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
    .wr_locked(wr_locked), .dev_state(dev_state), .config_crc_disable(config_crc_disable),
    .chk_start(chk_start), .link_crc_clear(link_crc_clear), .chk_busy(chk_busy),
    .chk_fault_in(chk_fault_in), .fault_clr(fault_clr), .fault_flags(fault_flags));
  stc_chk_model #(.LAT(2)) chk_logic (.clk(clk), .rst_b(rst_b), .start(chk_start), .fault(chk_fault_in));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // called at an edge; back to back calls give back to back writes
  task automatic wr(input logic [15:0] d, input stc_dev_state_t s, input logic cd);
    logic lk;
    stc_note_t n;
    lk = (s == STC_ST_ACTIVE) && !cd;
    shadow = lk ? {d[15], shadow[14:0]} : d & STC_CTRL_RW_MASK;
    n.rd = shadow;
    n.lc = d[15];
    n.st = lk ? 4'h0 : {d[8], d[7] && s == STC_ST_CONFIG2, d[5], d[0]};
    notes.push_back(n);
    wr_en <= 1'b1;
    wr_data <= d;
    dev_state <= s;
    config_crc_disable <= cd;
    @(posedge clk);
  endtask
  task automatic idle();
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  // monitor: one note per write strobe, locked or not
  always @(posedge clk) begin
    if (rst_b === 1'b1 && wr_en === 1'b1) begin
      chk("wr_locked", 16'(wr_locked), 16'(dev_state == STC_ST_ACTIVE && !config_crc_disable));
      #1;
      mon = notes.pop_front();
      chk("rd_data", rd_data, mon.rd);
      chk("chk_start", 16'(chk_start), 16'(mon.st));
      chk("link_crc_clear", 16'(link_crc_clear), 16'(mon.lc));
    end else if (rst_b === 1'b1) begin
      #1;
      chk("start_idle", 16'(chk_start), 16'h0000);
      chk("clear_idle", 16'(link_crc_clear), 16'h0000);
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int w;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk("rd_reset", rd_data, STC_CTRL_RST);
    @(posedge clk);
    wr(16'hFFFF, STC_ST_CONFIG2, 1'b0);
    wr(16'hFFFF, STC_ST_CONFIG2, 1'b0);
    wr(16'h0080, STC_ST_CONFIG1, 1'b0);
    wr(16'h81E1, STC_ST_ACTIVE, 1'b1);
    wr(16'h7FFF, STC_ST_ACTIVE, 1'b0);
    wr(16'h8000, STC_ST_ACTIVE, 1'b0);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      wr(seed[15:0], stc_dev_state_t'(seed[17:16]), seed[18]);
      if (seed[19]) idle();
    end
    idle();
    fault_clr <= stc_chk_t'(4'hF);
    repeat (12) @(posedge clk);
    fault_clr <= STC_CHK_NONE;
    @(posedge clk);
    #1 chk("flags_clear", 16'(fault_flags), 16'h0000);
    @(posedge clk);
    wr(16'h0021, STC_ST_CONFIG2, 1'b1);
    idle();
    #1 chk("chk_busy", 16'(chk_busy), 16'h0003);
    w = 0;
    while (fault_flags !== 4'h3 && w < 20) begin
      @(posedge clk);
      #1;
      w++;
    end
    #1 chk("fault_flags", 16'(fault_flags), 16'h0003);
    if (w == 20) begin
      n_fail++;
    end else begin
      chk("busy_done", 16'(chk_busy), 16'h0000);
      @(posedge clk);
      fault_clr <= stc_chk_t'(4'h1);
      @(posedge clk);
      fault_clr <= STC_CHK_NONE;
      #1 chk("flag_clr_one", 16'(fault_flags), 16'h0002);
    end
    report_and_stop();
  end
endmodule
